// ### sfl_defs.svh
// sfl_defs.svh: bit positions, reset values and timing counts of the function latch block
// assumes a single 10 MHz clock and a 21-bit serial word, control bits last
`ifndef SFL_DEFS_SVH
`define SFL_DEFS_SVH
`define SFL_SR_BITS       21
`define SFL_FUNC_BITS     19
`define SFL_FUNC_RESET    19'h00000
`define SFL_SR_RESET      21'h000000
`define SFL_F_CNT_RST     0
`define SFL_F_PWRDN       1
`define SFL_F_MUX_MSB     2
`define SFL_F_MUX_MID     3
`define SFL_F_MUX_LSB     4
`define SFL_F_POLARITY    5
`define SFL_F_PUMP_DIS    6
`define SFL_F_ACQ_EN      7
`define SFL_F_ACQ_CTL     8
`define SFL_F_TMO_EN      9
`define SFL_F_TMO_LO      10
`define SFL_F_TMO_HI      13
`define SFL_F_PD_MODE     17
`define SFL_CTL_REF       2'h0
`define SFL_CTL_FB        2'h2
`define SFL_CTL_FUNC      2'h1
`define SFL_CTL_INIT      2'h3
`define SFL_TMO_BASE      2'h3
`define SFL_CLK_NS        100
`define SFL_LD_IN_NS      15
`define SFL_LD_OUT_NS     30
`define SFL_LD_IN_CYC     ((`SFL_LD_IN_NS + `SFL_CLK_NS - 1) / `SFL_CLK_NS)
`define SFL_LD_OUT_CYC    (`SFL_LD_OUT_NS / `SFL_CLK_NS)
`define SFL_LD_FINE_CNT   5
`define SFL_LD_COARSE_CNT 3
`endif

// ### sfl_pkg.sv
// sfl_pkg: types shared by the function latch control modules
// assumes sfl_defs.svh is on the include path
package sfl_pkg;
  // power sequencing states, one-hot
  typedef enum logic [2:0] {
    SFL_PD_RUN  = 3'h1,
    SFL_PD_WAIT = 3'h2,
    SFL_PD_OFF  = 3'h4
  } sfl_pd_state_e;
  // multiplexed status pin selections
  typedef enum logic [2:0] {
    SFL_MUX_HIZ = 3'h0, SFL_MUX_REF = 3'h1, SFL_MUX_FB  = 3'h2, SFL_MUX_SER = 3'h3,
    SFL_MUX_LD  = 3'h4, SFL_MUX_OD  = 3'h5, SFL_MUX_HI  = 3'h6, SFL_MUX_LO  = 3'h7
  } sfl_mux_e;
  // {acquisition_control_bit, timeout_enable_bit}
  typedef logic [1:0] sfl_acq_mode_t;
endpackage

// ### sfl_if.sv
// sfl_if: carries decoded latch data and lock detect signals between the modules
// assumes all users sit on the same clock
`timescale 1ns/1ps
interface sfl_if;
  logic [18:0] func_word;
  logic        lock_precision;
  logic        go_load;
  logic        go_value;
  logic        ser_out;
  logic        fr_evt;
  logic        fp_evt;
  logic        lock_clr;
  logic        locked;
  logic        phase_win;
  logic        ref_leads;
  modport ser  (output func_word, lock_precision, go_load, go_value, ser_out);
  modport ld   (input fr_evt, fp_evt, lock_clr, lock_precision,
                output locked, phase_win, ref_leads);
  modport core (input func_word, lock_precision, go_load, go_value, ser_out,
                locked, phase_win, ref_leads, output fr_evt, fp_evt, lock_clr);
endinterface

// ### sfl_serial.sv
// sfl_serial: three-wire shift register and latch decode
// assumes serial pins are asynchronous to clk and toggle slower than clk / 4
`timescale 1ns/1ps
`include "sfl_defs.svh"
module sfl_serial (
  input wire logic clk,
  input wire logic rst,
  input wire logic ser_clk,
  input wire logic ser_data,
  input wire logic latch_strobe,
  sfl_if.ser       bus
);
  import sfl_pkg::*;
  logic [2:0]              s1_reg, s2_reg, s3_reg; // {strobe, data, clock}
  logic [`SFL_SR_BITS-1:0] sr_reg;
  logic                    clk_rise, le_rise;
  logic [1:0]              ctl;
  // two-stage synchronisers, third stage for edges
  always_ff @(posedge clk) begin
    if (rst) begin
      s1_reg <= 3'h0;
      s2_reg <= 3'h0;
      s3_reg <= 3'h0;
    end else begin
      s1_reg <= {latch_strobe, ser_data, ser_clk};
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
    end
  end
  assign clk_rise = s2_reg[0] & ~s3_reg[0];
  assign le_rise  = s2_reg[2] & ~s3_reg[2];
  assign ctl      = sr_reg[1:0]; // {c1, c2}
  // shift msb first, never gated by powerdown
  always_ff @(posedge clk) begin
    if (rst) sr_reg <= `SFL_SR_RESET;
    else if (clk_rise) sr_reg <= {sr_reg[`SFL_SR_BITS-2:0], s2_reg[1]};
  end
  // function and init words load the same latch
  always_ff @(posedge clk) begin
    if (rst) bus.func_word <= `SFL_FUNC_RESET;
    else if (le_rise && (ctl == `SFL_CTL_FUNC || ctl == `SFL_CTL_INIT))
      bus.func_word <= sr_reg[`SFL_SR_BITS-1:2];
  end
  // lock precision from the reference word
  always_ff @(posedge clk) begin
    if (rst) bus.lock_precision <= 1'b0;
    else if (le_rise && ctl == `SFL_CTL_REF) bus.lock_precision <= sr_reg[`SFL_SR_BITS-1];
  end
  // high gain go bit from the feedback word
  assign bus.go_load  = le_rise && (ctl == `SFL_CTL_FB);
  assign bus.go_value = sr_reg[`SFL_SR_BITS-1];
  assign bus.ser_out  = sr_reg[`SFL_SR_BITS-1];
endmodule

// ### sfl_lock.sv
// sfl_lock: phase error measurement and digital lock detect
// assumes fr_evt and fp_evt are one-cycle pulses on clk
`timescale 1ns/1ps
`include "sfl_defs.svh"
module sfl_lock #(
  parameter int ERR_W   = 8,
  parameter int IN_CYC  = `SFL_LD_IN_CYC,
  parameter int OUT_CYC = `SFL_LD_OUT_CYC
) (
  input wire logic clk,
  input wire logic rst,
  sfl_if.ld        lk
);
  import sfl_pkg::*;
  logic [ERR_W-1:0] err_reg;
  logic             win_reg, lead_reg, locked_reg;
  logic [2:0]       good_reg, need;
  logic             same, close, judge, good, bad;
  // one judgement per comparison, stuck window counts as bad
  assign same  = lk.fr_evt & lk.fp_evt & ~win_reg;
  assign close = win_reg & (lk.fr_evt | lk.fp_evt | (&err_reg));
  assign judge = same | close;
  assign good  = same | (err_reg < ERR_W'(IN_CYC));
  assign bad   = ~same & (err_reg > ERR_W'(OUT_CYC));
  assign need  = lk.lock_precision ? 3'(`SFL_LD_FINE_CNT) : 3'(`SFL_LD_COARSE_CNT);
  // edge-to-edge window, err counts its cycles
  always_ff @(posedge clk) begin
    if (rst || lk.lock_clr) begin
      win_reg  <= 1'b0;
      lead_reg <= 1'b0;
      err_reg  <= '0;
    end else if (close) begin
      win_reg <= 1'b0;
    end else if (!win_reg && (lk.fr_evt ^ lk.fp_evt)) begin
      win_reg  <= 1'b1;
      lead_reg <= lk.fr_evt;
      err_reg  <= ERR_W'(1);
    end else if (win_reg) begin
      err_reg <= err_reg + ERR_W'(1);
    end
  end
  // consecutive good count and lock flag
  always_ff @(posedge clk) begin
    if (rst || lk.lock_clr) begin
      locked_reg <= 1'b0;
      good_reg   <= 3'h0;
    end else if (judge) begin
      if (locked_reg) begin
        if (bad) begin
          locked_reg <= 1'b0;
          good_reg   <= 3'h0;
        end
      end else if (good) begin
        good_reg <= good_reg + 3'h1;
        if (good_reg + 3'h1 >= need) locked_reg <= 1'b1;
      end else begin
        good_reg <= 3'h0;
      end
    end
  end
  assign lk.locked    = locked_reg;
  assign lk.phase_win = win_reg;
  assign lk.ref_leads = lead_reg;
endmodule

// ### sfl_ctrl.sv
// sfl_ctrl: synthesizer function latch control, top level
// assumes all pins are asynchronous to clk; clk is 10 MHz
//
// Overview of operation
// - counter reset bit holds both counters; release is common to both
// - pump disable bit floats the charge pump; host passes it through
// - acquisition control and timeout enable bits pick one of four high-gain modes
// - with acquisition disabled the acquisition pin follows the control bit
// - timeout enable arms the counter that ends high gain
// - timeout counter loads from the four-bit timeout value field
// - chip enable low powers the part down at once
// - powerdown bit set: mode bit picks synchronous or asynchronous
// - synchronous powerdown waits for the next charge pump event
// - asynchronous powerdown takes effect as soon as the bit latches
// - latching a zero powerdown bit powers up at once
// - any powerdown holds reference, feedback and timeout counters loaded
// - any powerdown floats the charge pump
// - serial register keeps loading during powerdown
// - output select field picks the multiplexed pin source
// - open-drain lock detect stays high with narrow low pulses
// - lock asserts after 3 or 5 good cycles under 15 ns
// - lock drops on any cycle with error over 30 ns
// - lock precision bit high needs five cycles, low needs three
// - pump float or powerdown clears lock detect
// - words shift msb first, 21 bits, control 01 selects function latch
// - timeout counter steps once per comparison cycle
`timescale 1ns/1ps
`include "sfl_defs.svh"
module sfl_ctrl (
  input  wire logic            clk,
  input  wire logic            rst,
  input  wire logic            ser_clk,
  input  wire logic            ser_data,
  input  wire logic            latch_strobe,
  input  wire logic            chip_enable,
  input  wire logic            reference_divider_output,
  input  wire logic            feedback_divider_output,
  output logic                 multiplexed_status_pin,
  output logic                 multiplexed_status_oe_n,
  output logic                 acquisition_output_pin,
  output logic                 acquisition_output_oe_n,
  output logic                 charge_pump_up,
  output logic                 charge_pump_down,
  output logic                 charge_pump_output_hiz,
  output logic                 pump_gain_boost,
  output logic                 divider_quarter,
  output logic                 counters_hold,
  output logic                 powered_down,
  output logic                 lock_detect,
  output sfl_pkg::sfl_acq_mode_t acq_mode
);
  import sfl_pkg::*;

  sfl_if link ();

  // synchroniser stages for {ce, fp, fr}
  logic [2:0]    pin1_reg;
  logic [2:0]    pin2_reg;
  logic [2:0]    pin3_reg;
  logic          ce_s;
  logic          fr_s;
  logic          fp_s;
  logic          fr_evt;
  logic          fp_evt;

  // decoded latch fields
  logic          cnt_rst_bit;
  logic          powerdown_bit;
  logic          phase_polarity_bit;
  logic          pump_disable_bit;
  logic          acquisition_enable_bit;
  logic          acquisition_control_bit;
  logic          timeout_enable_bit;
  logic          powerdown_mode_bit;
  logic [3:0]    timeout_value_field;
  sfl_mux_e      output_select_field;

  // power sequencing
  sfl_pd_state_e pd_state_reg;
  sfl_pd_state_e pd_state_next;
  logic          pd_async;
  logic          pd_sync;
  logic          pd_now;

  // high gain acquisition
  logic          go_reg;
  logic [5:0]    tmo_reg;
  logic [5:0]    tmo_load;
  logic          tmo_run;
  logic          tmo_expire;
  logic          high_gain;

  // charge pump
  logic          pump_hiz;
  logic          up_raw;
  logic          dn_raw;

  // pin drive before the output flops
  logic          mux_val;
  logic          mux_oe_n;
  logic          acq_val;
  logic          acq_oe_n;

  // serial interface and latches
  sfl_serial u_serial (
    .clk          (clk),
    .rst          (rst),
    .ser_clk      (ser_clk),
    .ser_data     (ser_data),
    .latch_strobe (latch_strobe),
    .bus          (link.ser)
  );

  // phase measurement and lock detect
  sfl_lock #(
    .ERR_W   (8),
    .IN_CYC  (`SFL_LD_IN_CYC),
    .OUT_CYC (`SFL_LD_OUT_CYC)
  ) u_lock (
    .clk (clk),
    .rst (rst),
    .lk  (link.ld)
  );

  // two flops on every asynchronous pin, third for edges
  always_ff @(posedge clk) begin
    if (rst) begin
      pin1_reg <= 3'h0;
      pin2_reg <= 3'h0;
      pin3_reg <= 3'h0;
    end else begin
      pin1_reg <= {chip_enable, feedback_divider_output, reference_divider_output};
      pin2_reg <= pin1_reg;
      pin3_reg <= pin2_reg;
    end
  end

  assign fr_s   = pin2_reg[0];
  assign fp_s   = pin2_reg[1];
  assign ce_s   = pin2_reg[2];
  assign fr_evt = pin2_reg[0] & ~pin3_reg[0]; // comparison / charge pump event
  assign fp_evt = pin2_reg[1] & ~pin3_reg[1];

  // field decode; test bits are stored and left unused
  assign cnt_rst_bit             = link.func_word[`SFL_F_CNT_RST];
  assign powerdown_bit           = link.func_word[`SFL_F_PWRDN];
  assign phase_polarity_bit      = link.func_word[`SFL_F_POLARITY];
  assign pump_disable_bit        = link.func_word[`SFL_F_PUMP_DIS];
  assign acquisition_enable_bit  = link.func_word[`SFL_F_ACQ_EN];
  assign acquisition_control_bit = link.func_word[`SFL_F_ACQ_CTL];
  assign timeout_enable_bit      = link.func_word[`SFL_F_TMO_EN];
  assign timeout_value_field     = link.func_word[`SFL_F_TMO_HI:`SFL_F_TMO_LO];
  assign powerdown_mode_bit      = link.func_word[`SFL_F_PD_MODE];
  assign output_select_field     = sfl_mux_e'({link.func_word[`SFL_F_MUX_MSB],
                                               link.func_word[`SFL_F_MUX_MID],
                                               link.func_word[`SFL_F_MUX_LSB]});

  // powerdown requests from pin and latch
  assign pd_async = ~ce_s | (powerdown_bit & ~powerdown_mode_bit);
  assign pd_sync  = powerdown_bit & powerdown_mode_bit;

  // next power state
  always_comb begin
    pd_state_next = pd_state_reg;
    case (pd_state_reg)
      SFL_PD_RUN: begin
        if (pd_async) begin
          pd_state_next = SFL_PD_OFF;
        end else if (pd_sync) begin
          pd_state_next = SFL_PD_WAIT;
        end
      end
      SFL_PD_WAIT: begin
        if (pd_async) begin
          pd_state_next = SFL_PD_OFF;
        end else if (!powerdown_bit) begin
          pd_state_next = SFL_PD_RUN;
        end else if (fr_evt) begin
          pd_state_next = SFL_PD_OFF;
        end
      end
      SFL_PD_OFF: begin
        if (ce_s && !powerdown_bit) begin
          pd_state_next = SFL_PD_RUN;
        end
      end
      default: pd_state_next = SFL_PD_OFF;
    endcase
  end

  // power state register
  always_ff @(posedge clk) begin
    if (rst) begin
      pd_state_reg <= SFL_PD_OFF;
    end else begin
      pd_state_reg <= pd_state_next;
    end
  end

  // pin and asynchronous requests act without waiting for the state flop
  assign pd_now = (pd_state_reg == SFL_PD_OFF) | pd_async;

  // go bit: feedback word loads it, timeout expiry clears it
  always_ff @(posedge clk) begin
    if (rst) begin
      go_reg <= 1'b0;
    end else if (link.go_load) begin
      go_reg <= link.go_value;
    end else if (tmo_expire) begin
      go_reg <= 1'b0;
    end
  end

  // timeout length is 4 * value + 3 comparison cycles
  assign tmo_load   = {timeout_value_field, `SFL_TMO_BASE};
  assign high_gain  = acquisition_enable_bit & go_reg & ~pd_now;
  assign tmo_run    = high_gain & timeout_enable_bit;
  assign tmo_expire = tmo_run & fr_evt & (tmo_reg == 6'h1);

  // timeout counter sits loaded unless it is running
  always_ff @(posedge clk) begin
    if (rst) begin
      tmo_reg <= 6'h3;
    end else if (pd_now || !tmo_run) begin
      tmo_reg <= tmo_load;
    end else if (fr_evt && tmo_reg != 6'h0) begin
      tmo_reg <= tmo_reg - 6'h1;
    end
  end

  // charge pump floats on disable bit or any powerdown
  assign pump_hiz = pump_disable_bit | pd_now;

  // lock detect control
  assign link.fr_evt   = fr_evt & ~pd_now;
  assign link.fp_evt   = fp_evt & ~pd_now;
  assign link.lock_clr = pump_hiz;

  // pump direction follows which edge leads and the polarity bit
  assign up_raw = link.phase_win & (link.ref_leads == phase_polarity_bit) & ~pump_hiz;
  assign dn_raw = link.phase_win & (link.ref_leads != phase_polarity_bit) & ~pump_hiz;

  // multiplexed pin source, oe_n low while driving
  always_comb begin
    mux_val  = 1'b0;
    mux_oe_n = 1'b0;
    case (output_select_field)
      SFL_MUX_HIZ: mux_oe_n = 1'b1;
      SFL_MUX_REF: mux_val = fr_s;
      SFL_MUX_FB:  mux_val = fp_s;
      SFL_MUX_SER: mux_val = link.ser_out;
      SFL_MUX_LD:  mux_val = link.locked;
      SFL_MUX_OD:  mux_oe_n = ~link.phase_win;
      SFL_MUX_HI:  mux_val = 1'b1;
      SFL_MUX_LO:  mux_val = 1'b0;
      default:     mux_oe_n = 1'b1;
    endcase
  end

  // acquisition pin: general output or high-gain indicator
  always_comb begin
    acq_val  = 1'b0;
    acq_oe_n = 1'b1;
    if (!acquisition_enable_bit) begin
      acq_val  = acquisition_control_bit;
      acq_oe_n = 1'b0;
    end else if (high_gain) begin
      acq_val  = 1'b0;
      acq_oe_n = 1'b0;
    end
  end

  // output flops for pins and status
  always_ff @(posedge clk) begin
    if (rst) begin
      multiplexed_status_pin  <= 1'b0;
      multiplexed_status_oe_n <= 1'b1;
      acquisition_output_pin  <= 1'b0;
      acquisition_output_oe_n <= 1'b1;
    end else begin
      multiplexed_status_pin  <= mux_val;
      multiplexed_status_oe_n <= mux_oe_n;
      acquisition_output_pin  <= acq_val;
      acquisition_output_oe_n <= acq_oe_n;
    end
  end

  // charge pump drive
  always_ff @(posedge clk) begin
    if (rst) begin
      charge_pump_up   <= 1'b0;
      charge_pump_down <= 1'b0;
    end else begin
      charge_pump_up   <= up_raw;
      charge_pump_down <= dn_raw;
    end
  end

  // pump float flag, high from reset until powered up
  always_ff @(posedge clk) begin
    if (rst) begin
      charge_pump_output_hiz <= 1'b1;
    end else begin
      charge_pump_output_hiz <= pump_hiz;
    end
  end

  // gain and divider steering
  always_ff @(posedge clk) begin
    if (rst) begin
      pump_gain_boost <= 1'b0;
      divider_quarter <= 1'b0;
      acq_mode        <= 2'h0;
    end else begin
      pump_gain_boost <= go_reg & ~pd_now;
      divider_quarter <= high_gain & acquisition_control_bit;
      acq_mode        <= {acquisition_control_bit, timeout_enable_bit};
    end
  end

  // counter hold: both counters released in the same cycle
  always_ff @(posedge clk) begin
    if (rst) begin
      counters_hold <= 1'b1;
      powered_down  <= 1'b1;
    end else begin
      counters_hold <= cnt_rst_bit | pd_now;
      powered_down  <= pd_now;
    end
  end

  // lock detect status
  always_ff @(posedge clk) begin
    if (rst) begin
      lock_detect <= 1'b0;
    end else begin
      lock_detect <= link.locked;
    end
  end

endmodule

// ### sfl_ctrl_props.sv
// sfl_ctrl_props: port-level checks of the function latch control block
// assumes it is bound into sfl_ctrl and sees only that module's ports
`timescale 1ns/1ps
module sfl_ctrl_props (
  input wire logic                   clk,
  input wire logic                   rst,
  input wire logic                   chip_enable,
  input wire logic                   reference_divider_output,
  input wire logic                   feedback_divider_output,
  input wire logic                   charge_pump_output_hiz,
  input wire logic                   divider_quarter,
  input wire logic                   counters_hold,
  input wire logic                   powered_down,
  input wire logic                   lock_detect,
  input wire sfl_pkg::sfl_acq_mode_t acq_mode
);
  import sfl_pkg::*;
  logic [2:0] ref_cnt;
  logic [8:0] pin_age;
  logic [3:0] ctl_age;
  logic       ref_q;
  logic       fb_q;
  logic       pd_q;
  logic       hiz_q;
  // previous pin and state values for edge finding
  always_ff @(posedge clk) begin
    ref_q <= reference_divider_output;
    fb_q  <= feedback_divider_output;
    pd_q  <= powered_down;
    hiz_q <= charge_pump_output_hiz;
  end
  // reference edges seen since the loop was last powered and driven
  always_ff @(posedge clk) begin
    if (rst || powered_down || charge_pump_output_hiz) begin
      ref_cnt <= 3'h0;
    end else if (reference_divider_output && !ref_q && ref_cnt != 3'h7) begin
      ref_cnt <= ref_cnt + 3'h1;
    end
  end
  // cycles since a divider pin moved, covers the stuck-window limit
  always_ff @(posedge clk) begin
    if (rst || reference_divider_output != ref_q || feedback_divider_output != fb_q) begin
      pin_age <= 9'h000;
    end else if (pin_age != 9'h1FF) begin
      pin_age <= pin_age + 9'h001;
    end
  end
  // cycles since power or pump state moved
  always_ff @(posedge clk) begin
    if (rst || powered_down != pd_q || charge_pump_output_hiz != hiz_q) begin
      ctl_age <= 4'h0;
    end else if (ctl_age != 4'hF) begin
      ctl_age <= ctl_age + 4'h1;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  sequence s_ce_off;
    !chip_enable [*6];
  endsequence
  sequence s_pd_held;
    powered_down [*4];
  endsequence
  a_pd_float: assert property (s_pd_held |-> $past(charge_pump_output_hiz))
    else $error("pump driven in powerdown");
  a_pd_hold: assert property (s_pd_held |-> $past(counters_hold))
    else $error("counters free in powerdown");
  a_pd_unlock: assert property (s_pd_held |-> !$past(lock_detect))
    else $error("lock held in powerdown");
  a_ce_off: assert property (s_ce_off |-> powered_down)
    else $error("chip enable low but running");
  a_quarter_ctl: assert property (divider_quarter |-> acq_mode[1] || $past(acq_mode[1]))
    else $error("quarter dividers with control bit low");
  a_lock_count: assert property ($rose(lock_detect) |-> ref_cnt >= 3'h2)
    else $error("lock declared too early");
  a_lock_quiet: assert property ($rose(lock_detect) |-> !charge_pump_output_hiz && !powered_down)
    else $error("lock rose while floated or down");
  a_lock_keep: assert property ($fell(lock_detect) |-> (pin_age < 9'h12C || ctl_age < 4'h8)
      or ##[0:4] (powered_down || charge_pump_output_hiz))
    else $error("lock dropped without cause");
endmodule
bind sfl_ctrl sfl_ctrl_props sfl_ctrl_props_inst (
  .clk                      (clk),
  .rst                      (rst),
  .chip_enable              (chip_enable),
  .reference_divider_output (reference_divider_output),
  .feedback_divider_output  (feedback_divider_output),
  .charge_pump_output_hiz   (charge_pump_output_hiz),
  .divider_quarter          (divider_quarter),
  .counters_hold            (counters_hold),
  .powered_down             (powered_down),
  .lock_detect              (lock_detect),
  .acq_mode                 (acq_mode)
);

// ### sfl_host.sv
// sfl_host: behavioural host writing words over the three-wire link
// assumes the bench calls its tasks; link clock idles low between words
`timescale 1ns/1ps
`include "sfl_defs.svh"
module sfl_host #(
  parameter int HALF = 400
) (
  output logic ser_clk,
  output logic ser_data,
  output logic latch_strobe
);
  // idle levels
  initial begin
    ser_clk = 1'b0;
    ser_data = 1'b0;
    latch_strobe = 1'b0;
  end
  // shift a whole word msb first, then strobe it in
  task automatic send(input logic [20:0] w);
    for (int i = 20; i >= 0; i--) begin
      ser_data = w[i];
      #(HALF);
      ser_clk = 1'b1;
      #(HALF);
      ser_clk = 1'b0;
    end
    ser_data = ~w[0]; // no stale bit left on the line
    latch_strobe = 1'b1;
    #(HALF);
    latch_strobe = 1'b0;
    #(HALF);
  endtask
  // function latch word with test bits cleared and the polarity bit forced high
  task automatic func(input logic [18:0] f);
    logic [18:0] g;
    g = f & 19'h23FFF;
    g[`SFL_F_POLARITY] = 1'b1;
    send({g, `SFL_CTL_FUNC});
  endtask
endmodule

// ### tb_sfl_ctrl.sv
// tb_sfl_ctrl: directed bench for the function latch control block
// assumes sfl_host drives the link and the props checker is bound in
`timescale 1ns/1ps
`include "sfl_defs.svh"
`define CHK(n, e, a) begin cmp_count++; if ((a) !== (e)) begin errors++; \
  $display("unexpected %s exp %h got %h", n, e, a); end end
module tb_sfl_ctrl;
  import sfl_pkg::*;
  localparam logic [7:0] OE_TAB = 8'h21;
  localparam logic [7:0] PIN_TAB = 8'h46;
  localparam logic [7:0] PIN_MSK = 8'hDE;
  localparam logic [3:0] TMO_V = 4'h1;
  logic           clk, rst, ser_clk, ser_data, latch_strobe, chip_enable, ref_div, fb_div;
  logic           mux_pin, mux_oe_n, acq_pin, acq_oe_n, pump_up, pump_dn, pump_hiz;
  logic           boost, quarter, hold, pdn, lock;
  sfl_acq_mode_t  acq_mode;
  logic [18:0]    f;
  int             errors, cmp_count, i, k;
  sfl_host sfl_host_inst (.ser_clk(ser_clk), .ser_data(ser_data), .latch_strobe(latch_strobe));
  sfl_ctrl sfl_ctrl_inst (
    .clk(clk), .rst(rst), .ser_clk(ser_clk), .ser_data(ser_data),
    .latch_strobe(latch_strobe), .chip_enable(chip_enable),
    .reference_divider_output(ref_div), .feedback_divider_output(fb_div),
    .multiplexed_status_pin(mux_pin), .multiplexed_status_oe_n(mux_oe_n),
    .acquisition_output_pin(acq_pin), .acquisition_output_oe_n(acq_oe_n),
    .charge_pump_up(pump_up), .charge_pump_down(pump_dn), .charge_pump_output_hiz(pump_hiz),
    .pump_gain_boost(boost), .divider_quarter(quarter), .counters_hold(hold),
    .powered_down(pdn), .lock_detect(lock), .acq_mode(acq_mode));
  // 10 MHz clock
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // print counts and verdict, then stop
  task automatic end_of_test();
    $display("compares %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // bounded wait for a condition
  `define WT(c, m) begin k = 0; while (!(c) && k < 40) begin cyc(1); k++; end \
    `CHK(m, 1'b1, (c)) if (!(c)) end_of_test(); end
  // function word, then let it reach the outputs
  task automatic fl(input logic [18:0] w);
    sfl_host_inst.func(w);
    cyc(8);
  endtask
  // one comparison, feedback edge d cycles after reference edge
  task automatic cmp(input int d);
    cyc(1);
    ref_div = 1'b1;
    if (d > 0) cyc(d);
    fb_div = 1'b1;
    cyc(6);
    ref_div = 1'b0;
    fb_div = 1'b0;
    cyc(6);
  endtask
  // hang guard
  initial begin
    #9000000;
    errors++;
    end_of_test();
  end
  // main sequence
  initial begin
    rst = 1'b1;
    chip_enable = 1'b0;
    ref_div = 1'b0;
    fb_div = 1'b0;
    errors = 0;
    cmp_count = 0;
    cyc(4);
    rst = 1'b0;
    `CHK("pdn", 1'b1, pdn)
    `CHK("hiz", 1'b1, pump_hiz)
    `CHK("hold", 1'b1, hold)
    chip_enable = 1'b1;
    fl(19'h0);
    `WT(pdn === 1'b0, "up")
    `CHK("hiz", 1'b0, pump_hiz)
    fl(19'h1);
    `CHK("hold", 1'b1, hold)
    fl(19'h0);
    `CHK("hold", 1'b0, hold)
    $display("done power and reset");
    ref_div = 1'b1;
    fb_div = 1'b1;
    cyc(20);
    for (i = 0; i < 8; i++) begin
      f = 19'h0;
      {f[`SFL_F_MUX_MSB], f[`SFL_F_MUX_MID], f[`SFL_F_MUX_LSB]} = i[2:0];
      fl(f);
      `CHK("mux oe", OE_TAB[i], mux_oe_n)
      if (PIN_MSK[i]) `CHK("mux pin", PIN_TAB[i], mux_pin)
    end
    ref_div = 1'b0;
    fb_div = 1'b0;
    for (i = 0; i < 4; i++) begin
      f = 19'h0;
      f[`SFL_F_ACQ_CTL] = i[1];
      f[`SFL_F_TMO_EN] = i[0];
      fl(f);
      `CHK("acq mode", i[1:0], acq_mode)
      `CHK("acq pin", {1'b0, i[1]}, {acq_oe_n, acq_pin})
    end
    $display("done output select");
    cmp(3);
    cmp(0);
    cmp(0);
    `CHK("lock", 1'b0, lock)
    cmp(0);
    `CHK("lock", 1'b1, lock)
    f = 19'h0;
    {f[`SFL_F_MUX_MSB], f[`SFL_F_MUX_MID], f[`SFL_F_MUX_LSB]} = 3'h5;
    fl(f);
    `CHK("od oe", 1'b1, mux_oe_n)
    ref_div = 1'b1;
    cyc(5);
    `CHK("od oe", 1'b0, mux_oe_n)
    `CHK("pump up", 1'b1, pump_up)
    `CHK("pump dn", 1'b0, pump_dn)
    fb_div = 1'b1;
    cmp(0);
    `CHK("lock", 1'b0, lock)
    sfl_host_inst.send({1'b1, 18'h0, `SFL_CTL_REF});
    repeat (4) cmp(0);
    `CHK("lock", 1'b0, lock)
    cmp(0);
    `CHK("lock", 1'b1, lock)
    f = 19'h0;
    f[`SFL_F_PUMP_DIS] = 1'b1;
    fl(f);
    `CHK("hiz", 1'b1, pump_hiz)
    `CHK("lock", 1'b0, lock)
    $display("done lock detect");
    f = 19'h0;
    f[`SFL_F_ACQ_EN] = 1'b1;
    f[`SFL_F_ACQ_CTL] = 1'b1;
    f[`SFL_F_TMO_EN] = 1'b1;
    f[`SFL_F_TMO_HI:`SFL_F_TMO_LO] = TMO_V;
    fl(f);
    sfl_host_inst.send({1'b1, 18'h0, `SFL_CTL_FB});
    cyc(8);
    `CHK("boost", 1'b1, boost)
    `CHK("quarter", 1'b1, quarter)
    `CHK("acq pin", 2'b00, {acq_oe_n, acq_pin})
    repeat (4 * TMO_V + 2) cmp(0);
    `CHK("boost", 1'b1, boost)
    cmp(0);
    `CHK("boost", 1'b0, boost)
    `CHK("quarter", 1'b0, quarter)
    $display("done timeout");
    f = 19'h0;
    f[`SFL_F_PWRDN] = 1'b1;
    fl(f);
    `CHK("pdn", 1'b1, pdn)
    `CHK("hiz", 1'b1, pump_hiz)
    `CHK("hold", 1'b1, hold)
    fl(19'h0);
    `CHK("pdn", 1'b0, pdn)
    f[`SFL_F_PD_MODE] = 1'b1;
    fl(f);
    cyc(20);
    `CHK("pdn", 1'b0, pdn)
    cmp(0);
    `CHK("pdn", 1'b1, pdn)
    `CHK("lock", 1'b0, lock)
    fl(19'h0);
    `CHK("pdn", 1'b0, pdn)
    chip_enable = 1'b0;
    `WT(pdn === 1'b1, "ce off")
    chip_enable = 1'b1;
    `WT(pdn === 1'b0, "ce on")
    $display("done powerdown");
    end_of_test();
  end
endmodule
